// ===== verilog/host_micro_bus_defs.svh
// constants for the host microprocessor bus port
//==========================================================
// Contract
// RQ1: interface select pin picks micro bus port, PCI 3.3 V or PCI 5 V path
// RQ2: style pin high or open gives ready handshake, low gives data strobe handshake
// RQ3: board holds the style pin fixed, never changing it in operation
// RQ4: ready style uses read and write strobes; strobe style uses strobe and direction
// RQ5: address is sixteen low pins plus four selects; chip select and ready pins
// RQ6: width pin high gives 16-bit word transfers, low gives byte on low lines
// RQ7: host may change width pin per access with address setup and hold
// RQ8: two low address bits and width pin steer lanes of 32-bit word
// RQ9: every host strobe is synchronised to the internal clock before use
// RQ10: address decodes into registers, channel, data and connection memory regions
// RQ11: register blocks at 0x00100 upward; below and from 0x00700 reserved
// RQ12: channel memory reachable only while diagnostic mode is set
// RQ13: registers and connection memory answer without wait; reserved reads return zero
// RQ14: data memory waits for switching arbiter grant, ack held off meanwhile
// RQ15: byte 0 lowest address; writes update only addressed byte lanes
// RQ16: host holds strobe until ack, then releases it promptly
`ifndef HOST_MICRO_BUS_DEFS_SVH
`define HOST_MICRO_BUS_DEFS_SVH
// host path select codes
`define SEL_MICRO 2'h0
`define SEL_PCI_3V3 2'h1
`define SEL_PCI_5V 2'h2
// synchroniser reset: path 00, style 1, cs 1, rd 1, wr 1
`define SYNC_RESET 6'h0f
`define ACK_IDLE 1'b1
`define REG_RESET 32'h0000_0000
// address region codes on bits 19:16
`define SEG_REGS 4'h0
`define SEG_VCM 4'h1
`define SEG_DMEM 4'h2
`define SEG_CMEM 4'h4
// diagnostic mode bit in diagnostic_word_0, mode readback in diagnostic_word_1
`define DIAG_MODE_BIT 0
`define NREG 24
`define REG_NONE 5'h1f
`define OFS_MASTER_RESET 16'h0100
`define OFS_PHASE_MEM 16'h0104
`define OFS_FALLBACK 16'h0108
`define OFS_WATCHDOG 16'h010c
`define OFS_FAILSAFE 16'h0114
`define OFS_OOL 16'h0118
`define OFS_CLK_ERR 16'h0120
`define OFS_SYS_ERR 16'h0124
`define OFS_IDENT 16'h0128
`define OFS_DIAG0 16'h0140
`define OFS_DIAG1 16'h0144
`define OFS_DIAG2 16'h0148
`define OFS_PLL1 16'h0200
`define OFS_PLL2 16'h0204
`define OFS_DPLL1 16'h0208
`define OFS_DPLL2 16'h020c
`define OFS_NREF1 16'h0210
`define OFS_NREF2 16'h0214
`define OFS_CLK_OE 16'h0220
`define OFS_SCLK 16'h0224
`define OFS_LCLK 16'h0228
`define OFS_BP_RATE 16'h0300
`define OFS_LB_RATE 16'h0320
`define OFS_FG0 16'h0400
`endif

// ===== verilog/host_micro_bus_pkg.sv
// types for the host microprocessor bus port
`include "host_micro_bus_defs.svh"
`default_nettype none
package host_micro_bus_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_RUN = 4'b0010, ST_MEMWAIT = 4'b0100, ST_DONE = 4'b1000
    } port_state_t;
    typedef enum logic [1:0] {
        PATH_MICRO = `SEL_MICRO, PATH_PCI_3V3 = `SEL_PCI_3V3, PATH_PCI_5V = `SEL_PCI_5V
    } host_path_t;
    typedef enum logic [2:0] {RG_REGS, RG_VCM, RG_DMEM, RG_CMEM, RG_RSVD} region_t;
endpackage : host_micro_bus_pkg
`default_nettype wire

// ===== verilog/host_micro_bus_port.sv
// asynchronous microprocessor bus port with register file and memory access
`include "host_micro_bus_defs.svh"
`default_nettype none
module host_micro_bus_port #(
    parameter int CMEM_AW = 14,
    parameter logic [15:0] PART_ID = 16'h0a5c, // arbitrary value
    parameter logic [7:0] REVISION = 8'h03 // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // static straps, plus the width pin sampled per access
    input wire logic [1:0] host_interface_select,
    input wire logic handshake_style_pin,
    input wire logic word_byte_select_pin,
    // host address and control
    input wire logic [15:0] host_address_low,
    input wire logic host_address_bit16,
    input wire logic host_address_bit17,
    input wire logic host_address_bit18,
    input wire logic host_address_bit19,
    input wire logic host_chip_select_n,
    input wire logic read_or_data_strobe_pin,
    input wire logic write_or_direction_pin,
    output logic ready_or_ack_output,
    // host data lines, split three ways
    input wire logic [15:0] host_data_lines_in,
    output logic [15:0] host_data_lines_out,
    output logic host_data_lines_oe_n,
    // path status
    output host_micro_bus_pkg::host_path_t host_path,
    // data and channel memory request towards the switching arbiter
    output logic mem_req,
    output logic mem_vcm_sel,
    output logic [13:0] mem_addr,
    output logic mem_we,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic mem_grant,
    input wire logic [31:0] mem_rdata
);
    import host_micro_bus_pkg::*;

    //==========================================================
    // helper functions
    // byte lanes touched by one host access, byte 0 at lowest address
    function automatic logic [3:0] lanes(input logic [1:0] a, input logic word);
        if (word) begin
            lanes = a[1] ? 4'hc : 4'h3;
        end else begin
            lanes = 4'h1 << a;
        end
    endfunction : lanes

    // pick the addressed half or byte out of a dword
    function automatic logic [15:0] steer_rd(input logic [31:0] dw, input logic [1:0] a, input logic word);
        if (word) begin
            steer_rd = a[1] ? dw[31:16] : dw[15:0];
        end else begin
            case (a)
                2'h0: steer_rd = {8'h00, dw[7:0]};
                2'h1: steer_rd = {8'h00, dw[15:8]};
                2'h2: steer_rd = {8'h00, dw[23:16]};
                default: steer_rd = {8'h00, dw[31:24]};
            endcase
        end
    endfunction : steer_rd

    // region of a 20-bit host address
    function automatic region_t region_of(input logic [19:0] a);
        case (a[19:16])
            `SEG_REGS: region_of = RG_REGS;
            `SEG_VCM: region_of = RG_VCM;
            `SEG_DMEM: region_of = RG_DMEM;
            `SEG_CMEM: region_of = RG_CMEM;
            default: region_of = RG_RSVD;
        endcase
    endfunction : region_of

    // storage slot of a register offset, REG_NONE for reserved space
    function automatic logic [4:0] reg_index(input logic [15:0] ofs);
        case ({ofs[15:2], 2'h0})
            `OFS_MASTER_RESET: reg_index = 5'h00;
            `OFS_PHASE_MEM: reg_index = 5'h01;
            `OFS_FALLBACK: reg_index = 5'h02;
            `OFS_WATCHDOG: reg_index = 5'h03;
            `OFS_FAILSAFE: reg_index = 5'h04;
            `OFS_OOL: reg_index = 5'h05;
            `OFS_CLK_ERR: reg_index = 5'h06;
            `OFS_SYS_ERR: reg_index = 5'h07;
            `OFS_IDENT: reg_index = 5'h08;
            `OFS_DIAG0: reg_index = 5'h09;
            `OFS_DIAG1: reg_index = 5'h0a;
            `OFS_DIAG2: reg_index = 5'h0b;
            `OFS_PLL1: reg_index = 5'h0c;
            `OFS_PLL2: reg_index = 5'h0d;
            `OFS_DPLL1: reg_index = 5'h0e;
            `OFS_DPLL2: reg_index = 5'h0f;
            `OFS_NREF1: reg_index = 5'h10;
            `OFS_NREF2: reg_index = 5'h11;
            `OFS_CLK_OE: reg_index = 5'h12;
            `OFS_SCLK: reg_index = 5'h13;
            `OFS_LCLK: reg_index = 5'h14;
            `OFS_BP_RATE: reg_index = 5'h15;
            `OFS_LB_RATE: reg_index = 5'h16;
            `OFS_FG0: reg_index = 5'h17;
            default: reg_index = `REG_NONE;
        endcase
    endfunction : reg_index

    //==========================================================
    // pin synchroniser: three stages, a change counts when stages two and three agree
    logic [5:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic [5:0] raw_pins;
    assign raw_pins = {host_interface_select, handshake_style_pin, host_chip_select_n,
                       read_or_data_strobe_pin, write_or_direction_pin};

    // per-bit filter update
    always_comb begin
        filt_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r); // [RQ9]
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_r <= `SYNC_RESET;
            s2_r <= `SYNC_RESET;
            s3_r <= `SYNC_RESET;
            filt_r <= `SYNC_RESET;
        end else begin
            s1_r <= raw_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    // decoded strobes, both handshake styles
    logic port_en, style_ready, cs_q_n, rd_q, wr_q, strobe_on, is_read;
    assign port_en = (filt_r[5:4] == `SEL_MICRO); // [RQ1]
    assign style_ready = filt_r[3]; // [RQ2] [RQ3]
    assign cs_q_n = filt_r[2];
    assign rd_q = filt_r[1];
    assign wr_q = filt_r[0];
    // ready style: rd and wr are low strobes; strobe style: rd is the strobe, wr high reads
    assign strobe_on = !cs_q_n && (style_ready ? (!rd_q || !wr_q) : !rd_q); // [RQ4] [RQ5]
    assign is_read = style_ready ? !rd_q : wr_q; // [RQ4]

    //==========================================================
    // access state, register file and outputs
    port_state_t st_r, st_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic word_r, word_nxt, rd_r, rd_nxt;
    logic [15:0] wd_r, wd_nxt, dout_r, dout_nxt;
    logic oe_n_r, oe_n_nxt, ack_r, ack_nxt;
    logic [31:0] regs_r [`NREG];
    logic [31:0] regs_nxt [`NREG];
    logic [31:0] cmem [2**CMEM_AW];
    logic cm_we;
    logic [3:0] be;
    logic [31:0] wdw, rdw;
    logic [4:0] ridx;
    logic diag_mode;
    region_t reg_kind;
    host_path_t path_nxt;
    logic mreq_nxt, mvcm_nxt, mwe_nxt;
    logic [13:0] maddr_nxt;
    logic [3:0] mbe_nxt;
    logic [31:0] mwd_nxt;

    assign be = lanes(addr_r[1:0], word_r); // [RQ8] [RQ15]
    assign wdw = word_r ? {wd_r, wd_r} : {4{wd_r[7:0]}}; // [RQ6]
    assign ridx = reg_index(addr_r[15:0]);
    assign diag_mode = regs_r[5'h09][`DIAG_MODE_BIT];
    // channel memory without diagnostic mode behaves as reserved space
    assign reg_kind = (region_of(addr_r) == RG_VCM && !diag_mode) ? RG_RSVD : region_of(addr_r); // [RQ10] [RQ12]

    // register read dword; reserved offsets read zero
    always_comb begin
        rdw = `REG_RESET;
        if (ridx == 5'h08) begin
            rdw = {PART_ID, 8'h00, REVISION};
        end else if (ridx == 5'h0a) begin
            rdw = {regs_r[5'h0a][31:8], 3'h0, style_ready, word_r, port_en, filt_r[5:4]};
        end else if (ridx != `REG_NONE) begin
            rdw = regs_r[ridx]; // [RQ11] [RQ13]
        end
    end

    // next-state logic of the access sequencer
    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        word_nxt = word_r;
        rd_nxt = rd_r;
        wd_nxt = wd_r;
        dout_nxt = dout_r;
        regs_nxt = regs_r;
        cm_we = 1'b0;
        mreq_nxt = mem_req;
        mvcm_nxt = mem_vcm_sel;
        maddr_nxt = mem_addr;
        mwe_nxt = mem_we;
        mbe_nxt = mem_be;
        mwd_nxt = mem_wdata;
        path_nxt = host_path_t'(filt_r[5:4]); // [RQ1]
        case (st_r)
            ST_IDLE: begin
                if (port_en && strobe_on) begin
                    addr_nxt = {host_address_bit19, host_address_bit18, host_address_bit17,
                                host_address_bit16, host_address_low}; // [RQ5]
                    word_nxt = word_byte_select_pin; // [RQ6] [RQ7]
                    rd_nxt = is_read;
                    wd_nxt = host_data_lines_in;
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                case (reg_kind)
                    RG_REGS: begin
                        dout_nxt = steer_rd(rdw, addr_r[1:0], word_r); // [RQ8]
                        if (!rd_r && ridx != `REG_NONE && ridx != 5'h08) begin
                            for (int i = 0; i < 4; i++) begin
                                if (be[i]) begin
                                    regs_nxt[ridx][8*i +: 8] = wdw[8*i +: 8]; // [RQ15]
                                end
                            end
                        end
                        st_nxt = ST_DONE; // [RQ13]
                    end
                    RG_CMEM: begin
                        dout_nxt = steer_rd(cmem[addr_r[CMEM_AW+1:2]], addr_r[1:0], word_r);
                        cm_we = !rd_r;
                        st_nxt = ST_DONE; // [RQ13]
                    end
                    RG_DMEM, RG_VCM: begin
                        mreq_nxt = 1'b1; // [RQ14]
                        mvcm_nxt = (reg_kind == RG_VCM); // [RQ12]
                        maddr_nxt = addr_r[15:2];
                        mwe_nxt = !rd_r;
                        mbe_nxt = be;
                        mwd_nxt = wdw;
                        st_nxt = ST_MEMWAIT;
                    end
                    default: begin
                        dout_nxt = 16'h0000; // [RQ13]
                        st_nxt = ST_DONE;
                    end
                endcase
            end
            ST_MEMWAIT: begin
                // ack is held off until the arbiter grants the slot
                if (mem_grant) begin
                    mreq_nxt = 1'b0;
                    dout_nxt = steer_rd(mem_rdata, addr_r[1:0], word_r); // [RQ14]
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!strobe_on) begin
                    st_nxt = ST_IDLE; // [RQ16]
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // ready style: high idle, low busy; strobe style: low only while done
        if (style_ready) begin
            ack_nxt = (st_nxt == ST_IDLE) || (st_nxt == ST_DONE); // [RQ2]
        end else begin
            ack_nxt = (st_nxt != ST_DONE); // [RQ2]
        end
        oe_n_nxt = !(st_nxt == ST_DONE && rd_nxt && strobe_on); // [RQ6]
    end

    // sequencer and output registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            addr_r <= 20'h0_0000;
            word_r <= 1'b1;
            rd_r <= 1'b0;
            wd_r <= 16'h0000;
            dout_r <= 16'h0000;
            oe_n_r <= 1'b1;
            ack_r <= `ACK_IDLE;
            host_path <= PATH_MICRO;
            mem_req <= 1'b0;
            mem_vcm_sel <= 1'b0;
            mem_addr <= 14'h0000;
            mem_we <= 1'b0;
            mem_be <= 4'h0;
            mem_wdata <= 32'h0000_0000;
            for (int i = 0; i < `NREG; i++) begin
                regs_r[i] <= `REG_RESET;
            end
        end else begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            word_r <= word_nxt;
            rd_r <= rd_nxt;
            wd_r <= wd_nxt;
            dout_r <= dout_nxt;
            oe_n_r <= oe_n_nxt;
            ack_r <= ack_nxt;
            host_path <= path_nxt;
            mem_req <= mreq_nxt;
            mem_vcm_sel <= mvcm_nxt;
            mem_addr <= maddr_nxt;
            mem_we <= mwe_nxt;
            mem_be <= mbe_nxt;
            mem_wdata <= mwd_nxt;
            regs_r <= regs_nxt;
        end
    end

    // connection memory, byte-lane writes, no reset on storage
    always_ff @(posedge mclk) begin
        if (cm_we) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) begin
                    cmem[addr_r[CMEM_AW+1:2]][8*i +: 8] <= wdw[8*i +: 8]; // [RQ15]
                end
            end
        end
    end

    assign ready_or_ack_output = ack_r;
    assign host_data_lines_out = dout_r;
    assign host_data_lines_oe_n = oe_n_r;
endmodule : host_micro_bus_port
`default_nettype wire

// ===== tb/host_micro_bus_port_props.sv
// assertion checker for the host bus port
`default_nettype none
module host_micro_bus_port_props
    import host_micro_bus_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // straps and host pins
    input wire logic handshake_style_pin,
    input wire logic word_byte_select_pin,
    input wire logic [15:0] host_address_low,
    input wire logic host_address_bit16,
    input wire logic host_address_bit17,
    input wire logic host_address_bit18,
    input wire logic host_address_bit19,
    input wire logic read_or_data_strobe_pin,
    input wire logic ready_or_ack_output,
    input wire logic [15:0] host_data_lines_out,
    input wire logic host_data_lines_oe_n,
    input wire host_micro_bus_pkg::host_path_t host_path,
    // memory request
    input wire logic mem_req,
    input wire logic mem_vcm_sel,
    input wire logic [13:0] mem_addr,
    input wire logic mem_we,
    input wire logic [3:0] mem_be,
    input wire logic mem_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // properties
    logic [3:0] seg;
    assign seg = {host_address_bit19, host_address_bit18, host_address_bit17, host_address_bit16};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_req_holds: assert property (mem_req && !mem_grant |=> mem_req)
        else $error("memory request dropped early");
    chk_req_release: assert property (mem_req && mem_grant |=> !mem_req)
        else $error("memory request held after grant");
    chk_ack_after_grant: assert property (mem_req && mem_grant |->
        (ready_or_ack_output != handshake_style_pin) ##1 (ready_or_ack_output == handshake_style_pin))
        else $error("ack not two edges after grant");
    chk_fast_answer: assert property (handshake_style_pin && $fell(ready_or_ack_output)
        && seg != 4'h1 && seg != 4'h2 |-> !ready_or_ack_output ##1 ready_or_ack_output)
        else $error("fast region ack late");
    chk_mem_region: assert property ($rose(mem_req) |-> seg == (mem_vcm_sel ? 4'h1 : 4'h2))
        else $error("memory request from wrong region");
    chk_mem_addr: assert property (mem_req |-> mem_addr == host_address_low[15:2])
        else $error("memory dword index wrong");
    chk_lane_enables: assert property (mem_req && mem_we |-> mem_be == (word_byte_select_pin ?
        4'h3 << {host_address_low[1], 1'b0} : 4'h1 << host_address_low[1:0]))
        else $error("byte enables wrong");
    chk_byte_upper: assert property (!host_data_lines_oe_n && !word_byte_select_pin
        |-> host_data_lines_out[15:8] == 8'h00)
        else $error("upper lines driven in byte mode");
    chk_strobe_sync: assert property ($fell(read_or_data_strobe_pin) |=> ready_or_ack_output [*2])
        else $error("strobe acted on before sync");
    chk_pci_quiet: assert property (host_path != PATH_MICRO
        |-> ready_or_ack_output && host_data_lines_oe_n && !mem_req)
        else $error("port active in pci mode");
    cover property (mem_req && mem_grant && mem_vcm_sel);
    cover property (!host_data_lines_oe_n && !word_byte_select_pin);
    cover property (!handshake_style_pin && !ready_or_ack_output);
endmodule : host_micro_bus_port_props
bind host_micro_bus_port host_micro_bus_port_props u_props (
    .mclk, .rst_n, .handshake_style_pin, .word_byte_select_pin, .host_address_low,
    .host_address_bit16, .host_address_bit17, .host_address_bit18, .host_address_bit19,
    .read_or_data_strobe_pin, .ready_or_ack_output, .host_data_lines_out, .host_data_lines_oe_n,
    .host_path, .mem_req, .mem_vcm_sel, .mem_addr, .mem_we, .mem_be, .mem_grant
);
`default_nettype wire

// ===== tb/micro_host_model.sv
// external processor driving the asynchronous host bus
`default_nettype none
module micro_host_model (
    // clock and device answer
    input wire logic mclk,
    input wire logic style,
    input wire logic ack,
    input wire logic [15:0] rd_data,
    // bus pins
    output logic [19:0] addr,
    output logic cs_n,
    output logic strobe,
    output logic dir,
    output logic wide,
    output logic [15:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // bus driver
    logic act = 1'b0;
    logic [15:0] wd_q = 16'h0000;
    logic [15:0] junk = 16'h0000;
    initial begin
        {cs_n, strobe, dir, wide} = 4'hf;
        addr = '0;
    end
    // released data lines wander so stale write data never looks valid
    always @(posedge mclk) junk <= junk + 16'h9e37;
    assign wdata = act ? wd_q : junk;
    task automatic access(input bit we, input logic [19:0] a, input bit w, input logic [15:0] d,
                          output logic [15:0] q, output bit tmo);
        int n;
        n = 0;
        @(posedge mclk);
        addr <= a;
        wide <= w;
        wd_q <= d;
        act <= 1'b1;
        cs_n <= 1'b0;
        strobe <= style ? we : 1'b0;
        dir <= !we;
        @(negedge mclk);
        // ready style shows busy first, then completion
        while (style && ack !== 1'b0 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        while (ack !== style && n < 300) begin
            @(negedge mclk);
            n++;
        end
        q = rd_data;
        tmo = (n >= 300);
        @(posedge mclk);
        cs_n <= 1'b1;
        strobe <= 1'b1;
        dir <= 1'b1;
        act <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : access
    task automatic probe(output int lows);
        lows = 0;
        @(posedge mclk);
        cs_n <= 1'b0;
        strobe <= 1'b0;
        repeat (20) begin
            @(negedge mclk);
            lows += (ack !== 1'b1);
        end
        @(posedge mclk);
        cs_n <= 1'b1;
        strobe <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask : probe
endmodule : micro_host_model
`default_nettype wire

// ===== tb/test_host_micro_bus_port.sv
// self-checking bench for the host bus port
`default_nettype none
module test_host_micro_bus_port;
    timeunit 1ns;
    timeprecision 1ps;
    import host_micro_bus_pkg::*;
    // ==========================================
    // signals and instances
    localparam logic [15:0] ID_PART = 16'h3c5a; // arbitrary value
    localparam logic [7:0] ID_REV = 8'h07; // arbitrary value
    logic mclk = 0, rst_n = 0, sty = 1, mem_grant = 0;
    logic [1:0] sel = 2'h0;
    logic [31:0] mem_rdata = '0, got_wd, mwd;
    logic [3:0] got_be, mbe;
    logic got_we, got_vcm, ack, oe_n, mreq, mvcm, mwe, cs_n, stb, dir, wide, tmo;
    logic [19:0] ha;
    logic [15:0] hd_in, hd_out, q, rs = 16'h003f;
    logic [13:0] maddr;
    host_path_t hpath;
    int num_errors = 0, n_checks = 0, cyc = 0, gcnt = 0, gdly = 0;
    always #2 mclk = ~mclk;
    host_micro_bus_port #(.PART_ID(ID_PART), .REVISION(ID_REV)) DUT (
        .mclk(mclk), .rst_n(rst_n), .host_interface_select(sel), .handshake_style_pin(sty),
        .word_byte_select_pin(wide), .host_address_low(ha[15:0]), .host_address_bit16(ha[16]),
        .host_address_bit17(ha[17]), .host_address_bit18(ha[18]), .host_address_bit19(ha[19]),
        .host_chip_select_n(cs_n), .read_or_data_strobe_pin(stb), .write_or_direction_pin(dir),
        .ready_or_ack_output(ack), .host_data_lines_in(hd_in), .host_data_lines_out(hd_out),
        .host_data_lines_oe_n(oe_n), .host_path(hpath), .mem_req(mreq), .mem_vcm_sel(mvcm),
        .mem_addr(maddr), .mem_we(mwe), .mem_be(mbe), .mem_wdata(mwd), .mem_grant(mem_grant),
        .mem_rdata(mem_rdata));
    // released data lines show the inverse, so a missing output enable spoils the read
    micro_host_model HOST (.mclk(mclk), .style(sty), .ack(ack), .rd_data(oe_n ? ~hd_out : hd_out), .addr(ha),
        .cs_n(cs_n), .strobe(stb), .dir(dir), .wide(wide), .wdata(hd_in));
    // arbiter stand-in: grants after a random stall
    always @(posedge mclk) begin
        mem_grant <= 1'b0;
        if (mreq && !mem_grant) begin
            if (gdly == 0) begin
                mem_grant <= 1'b1;
                mem_rdata <= {rs, ~rs};
                got_wd <= mwd;
                got_be <= mbe;
                got_we <= mwe;
                got_vcm <= mvcm;
                gcnt <= gcnt + 1;
                gdly <= rs[2:0];
            end else begin
                gdly <= gdly - 1;
            end
        end
    end
    // cycle ceiling against hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            test_done();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction : lfsr
    // lane seen by the host: half in word mode, addressed byte on the low lines in byte mode
    function automatic logic [15:0] lane(input logic [31:0] w, input logic [1:0] a, input bit wd);
        return wd ? w[16*a[1] +: 16] : {8'h00, w[8*a +: 8]};
    endfunction : lane
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic xfer(input bit we, input logic [19:0] a, input bit wd, input logic [15:0] d);
        HOST.access(we, a, wd, d, q, tmo);
        if (tmo) begin
            num_errors++;
            test_done();
        end
    endtask : xfer
    // word writes, byte reads, then one byte write merged into the dword
    task automatic reg_test(input logic [19:0] a);
        logic [31:0] w;
        int i;
        w = {lfsr(rs), rs};
        rs = lfsr(lfsr(rs));
        xfer(1, a, 1, w[15:0]);
        xfer(1, a | 20'h0_0002, 1, w[31:16]);
        for (i = 0; i < 4; i++) begin
            xfer(0, {a[19:2], i[1:0]}, 0, 16'h0000);
            check(q, lane(w, i[1:0], 0));
        end
        i = rs[1:0];
        w[8*i +: 8] = rs[7:0];
        xfer(1, {a[19:2], i[1:0]}, 0, rs);
        rs = lfsr(rs);
        xfer(0, a | 20'h0_0001, 1, 16'h0000);
        check(q, w[15:0]);
        xfer(0, a | 20'h0_0002, 1, 16'h0000);
        check(q, w[31:16]);
    endtask : reg_test
    initial begin
        static logic [19:0] regs [4] = '{20'h0_0100, 20'h0_0228, 20'h0_0320, 20'h0_0400};
        static logic [19:0] rsv [5] = '{20'h0_0000, 20'h0_00fc, 20'h0_0700, 20'h3_0000, 20'h5_fff0};
        int s, k;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (s = 1; s >= 0; s--) begin
            sty <= s[0];
            repeat (8) @(posedge mclk);
            foreach (regs[j]) reg_test(regs[j]);
            reg_test(20'h4_0000 | {4'h0, rs[13:0], 2'b00});
            foreach (rsv[j]) begin
                xfer(1, rsv[j], 1, rs);
                xfer(0, rsv[j], 1, 16'h0000);
                check(q, 16'h0000);
            end
            xfer(1, 20'h0_0128, 1, 16'hffff);
            xfer(0, 20'h0_0128, 1, 16'h0000);
            check(q, {8'h00, ID_REV});
            xfer(0, 20'h0_012a, 1, 16'h0000);
            check(q, ID_PART);
            k = gcnt;
            rs = lfsr(rs);
            xfer(1, 20'h2_0006, 1, rs);
            check({got_we, got_vcm, got_be, got_wd[31:16]}, {2'b10, 4'hc, rs});
            xfer(0, 20'h2_0005, 0, 16'h0000);
            check(q, lane(mem_rdata, 2'h1, 0));
            xfer(0, 20'h1_0010, 1, 16'h0000);
            check(q, 16'h0000);
            check(gcnt, k + 2);
            xfer(1, 20'h0_0140, 0, 16'h0001);
            xfer(0, 20'h1_0012, 1, 16'h0000);
            check({got_vcm, q}, {1'b1, lane(mem_rdata, 2'h2, 1)});
            xfer(1, 20'h0_0140, 0, 16'h0000);
        end
        for (s = 1; s < 3; s++) begin
            sel <= s[1:0];
            repeat (8) @(posedge mclk);
            check(hpath, s);
            HOST.probe(k);
            check(k, 0);
        end
        test_done();
    end
endmodule : test_host_micro_bus_port
`default_nettype wire
